// file: rtl/drc_pkg.sv
// Package for the drive reference and ramp configuration block.
// Assumes a 200 MHz clock and an AXI4-Lite master with 32-bit data.
package drc_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_FMIN = 8'h00;
  localparam logic [7:0] ADDR_FMAX = 8'h04;
  localparam logic [7:0] ADDR_ACC = 8'h08;
  localparam logic [7:0] ADDR_DEC = 8'h0C;
  localparam logic [7:0] ADDR_REFA = 8'h10;
  localparam logic [7:0] ADDR_REFB = 8'h14;
  localparam logic [7:0] ADDR_ILIM = 8'h18;
  localparam logic [7:0] ADDR_CURVE = 8'h1C;
  localparam logic [7:0] ADDR_OPT = 8'h20;
  localparam logic [7:0] ADDR_CONCEAL = 8'h24;
  localparam logic [7:0] ADDR_LOCK = 8'h28;
  localparam logic [7:0] ADDR_PANEL = 8'h2C;
  localparam logic [7:0] ADDR_SSL = 8'h30;
  localparam logic [7:0] ADDR_DI3 = 8'h34;
  localparam logic [7:0] ADDR_STATUS = 8'h38;
  localparam logic [7:0] ADDR_FOUT = 8'h3C;
  localparam logic [7:0] ADDR_ADV_GROUP = 8'h40;
  // Frequencies in Hz, times in 0.1 s, current in 0.1 x nominal
  localparam logic [8:0] FMIN_RST = 9'h000;
  localparam logic [8:0] FMAX_RST = 9'h03C;
  localparam logic [8:0] CEIL_STD = 9'h078;
  localparam logic [8:0] CEIL_EXT = 9'h1F4;
  localparam logic [8:0] FMAX_EXT_CMD = 9'h078;
  localparam logic [8:0] FMAX_STD_CMD = 9'h077;
  localparam logic [14:0] RAMP_RST = 15'h001E;
  localparam logic [14:0] RAMP_MIN = 15'h0001;
  localparam logic [14:0] RAMP_MAX = 15'h7530;
  localparam logic [2:0] REFA_RST = 3'h1;
  localparam logic [2:0] REFB_RST = 3'h0;
  localparam logic [2:0] REF_MAX = 3'h4;
  localparam logic [4:0] ILIM_RST = 5'h0F;
  localparam logic [4:0] ILIM_MIN = 5'h01;
  localparam logic [4:0] ILIM_MAX = 5'h19;
  localparam logic [1:0] CURVE_MAX = 2'h2;
  localparam logic [2:0] SSL_MOTPOT = 3'h4;
  localparam logic [3:0] DI3_MOTPOT = 4'hA;
  localparam logic [3:0] DI3_RST = 4'h7;
  // Panel reference: 0.01 Hz units standard, 0.1 Hz extended
  localparam logic [15:0] PANEL_STEP_STD = 16'h0001;
  localparam logic [15:0] PANEL_STEP_EXT = 16'h000A;
  // Frequency kept in 0.01 Hz units, 16-bit fraction accumulator
  localparam int FRAC_W = 16;
  localparam logic [15:0] CENTI_PER_HZ = 16'h0064;
  localparam int CLK_HZ = 200_000_000;
  localparam int DECI_S_HZ = 10;
  // One ramp tick per millisecond
  localparam int TICK_MS = 1;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int TICKS_PER_DECI = 100 / TICK_MS;
  // Motor potentiometer slew in 0.01 Hz per tick
  localparam logic [15:0] MOTPOT_STEP = 16'h0001;
  // Voltage curve points: output as fraction of 0..1023
  localparam logic [9:0] V_FULL = 10'h3FF;
  localparam logic [9:0] BOOST_V = 10'h033;
  localparam logic [15:0] BOOST_FREQ = 16'h03E8;
  localparam logic [15:0] FWP_RST = 16'h1770;

  typedef enum logic [1:0] {
    DRC_RUN_STOPPED,
    DRC_RUN_RAMP,
    DRC_RUN_HOLD
  } drc_run_e;

  typedef struct packed {
    logic [15:0] fout;
    logic [9:0] vout;
    logic [4:0] ilim;
    logic running;
    logic ext_range;
  } drc_out_s;
endpackage : drc_pkg

// file: rtl/drc_top.sv
// Drive reference, ramp and basic parameter set behind an AXI4-Lite slave.
// Assumes synchronous digital inputs and analog values already digitized.
//
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps

// Functional notes
// [R1] Output frequency stays between programmed minimum and maximum; the [R5] write keeps a minimum above 119 Hz, so output exceeds maximum.
// [R2] After reset both frequency limits are capped at 120 Hz.
// [R3] Writing max 120 Hz while stopped raises ceiling to 500 Hz.
// [R4] Extended range coarsens panel reference step from 0.01 Hz to 0.1 Hz.
// [R5] Writing max 119 Hz while stopped restores 120 Hz ceiling.
// [R6] Ramp times span min to max, 0.1 s steps, default 3.0 s.
// [R7] Frequency slews at span over ramp time, stopping at target.
// [R8] Analog input may shorten acceleration and deceleration times.
// [R9] Reference code: 0 voltage, 1 current, 2 panel, 3/4 motor pot.
// [R10] Motor pot rises with input two, falls with input three.
// [R11] Code 4 reloads motor pot with minimum frequency at every stop.
// [R12] Source A code 3/4 forces start logic 4 and input three function 10.
// [R13] Source B reference decodes the same five codes.
// [R14] Source select open uses A, closed uses B.
// [R15] Current capped at limit; analog input may lower it.
// [R16] Curve 0: linear voltage to field weakening point, then nominal.
// [R17] Curve 1: squared voltage to field weakening point.
// [R18] Optimization 1 adds low-frequency torque boost; 0 none.
// [R19] Conceal 1 exposes only basic group; 0 exposes all.
// [R20] Lock 1 rejects all parameter changes except writes to the lock register; 0 accepts.
// [R21] Marked basic settings change only while the drive is stopped.
module drc_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic run_cmd,
  input wire logic source_a_input_two,
  input wire logic source_a_input_three,
  input wire logic source_select_input,
  input wire logic [15:0] ain_volt_ref,
  input wire logic [15:0] ain_curr_ref,
  input wire logic [7:0] ain_ramp_scale,
  input wire logic [4:0] ain_ilim,
  output drc_pkg::drc_out_s drive_out
);
  import drc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Parameter registers
  logic [8:0] fmin_ff;
  logic [8:0] fmax_ff;
  logic ext_ff;
  logic [14:0] acc_ff;
  logic [14:0] dec_ff;
  logic [2:0] refa_ff;
  logic [2:0] refb_ff;
  logic [4:0] ilim_ff;
  logic [1:0] curve_ff;
  logic opt_ff;
  logic conceal_ff;
  logic lock_ff;
  logic [15:0] panel_ff;
  logic [2:0] ssl_ff;
  logic [3:0] di3_ff;
  logic [31:0] adv_ff;
  // Bus state
  logic [7:0] awaddr_ff;
  logic aw_have_ff;
  logic [31:0] wdata_ff;
  logic w_have_ff;
  logic wr_go;
  logic wr_ok;
  logic [1:0] wr_resp;
  // Drive state
  drc_run_e run_ff;
  logic [15:0] fout_ff;
  logic [FRAC_W-1:0] frac_ff;
  logic [15:0] motpot_ff;
  logic [17:0] tick_cnt_ff;
  logic tick;
  function automatic logic [15:0] hz_to_centi(input logic [8:0] hz);
    hz_to_centi = 16'(32'(hz) * 32'(CENTI_PER_HZ));
  endfunction : hz_to_centi
  function automatic logic [15:0] clamp16(input logic [15:0] v, lo, hi);
    clamp16 = (v < lo) ? lo : (v > hi) ? hi : v;
  endfunction : clamp16
  function automatic logic is_basic(input logic [7:0] a);
    is_basic = (a <= ADDR_FOUT);
  endfunction : is_basic
  function automatic logic addr_bad(input logic [7:0] a, input logic hide);
    addr_bad = a[1:0] != 2'b00 || a > ADDR_ADV_GROUP || (hide && !is_basic(a)); // [R19]
  endfunction : addr_bad
  logic stopped;
  assign stopped = (run_ff == DRC_RUN_STOPPED);

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel
  assign wr_go = aw_have_ff && w_have_ff && !s_axi_bvalid;
  assign wr_ok = !(lock_ff && awaddr_ff != ADDR_LOCK) && // [R20]
                 !addr_bad(awaddr_ff, conceal_ff);
  assign wr_resp = wr_ok ? 2'b00 : 2'b10;
  always_ff @(posedge clk) begin
    if (rst) begin
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else if (ce) begin
      s_axi_awready <= !aw_have_ff && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_have_ff && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_resp;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_have_ff <= 1'b0;
        w_have_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parameter writes
  logic [8:0] ceil_now;
  logic [8:0] wr_hz;
  logic [14:0] wr_ramp;
  logic [4:0] wr_ilim;
  assign ceil_now = ext_ff ? CEIL_EXT : CEIL_STD;
  assign wr_hz = (wdata_ff[31:9] != 23'h0) ? 9'h1FF : wdata_ff[8:0];
  assign wr_ramp = (wdata_ff[31:15] != 17'h0) ? RAMP_MAX :
                   (wdata_ff[14:0] < RAMP_MIN) ? RAMP_MIN :
                   (wdata_ff[14:0] > RAMP_MAX) ? RAMP_MAX : wdata_ff[14:0];
  assign wr_ilim = (wdata_ff[31:5] != 27'h0) ? ILIM_MAX :
                   (wdata_ff[4:0] < ILIM_MIN) ? ILIM_MIN :
                   (wdata_ff[4:0] > ILIM_MAX) ? ILIM_MAX : wdata_ff[4:0];
  always_ff @(posedge clk) begin
    if (rst) begin
      fmin_ff <= FMIN_RST;
      fmax_ff <= FMAX_RST;
      ext_ff <= 1'b0; // [R2]
      acc_ff <= RAMP_RST; // [R6]
      dec_ff <= RAMP_RST;
      refa_ff <= REFA_RST;
      refb_ff <= REFB_RST;
      ilim_ff <= ILIM_RST;
      curve_ff <= 2'h0;
      opt_ff <= 1'b0;
      conceal_ff <= 1'b0;
      lock_ff <= 1'b0;
      panel_ff <= 16'h0000;
      ssl_ff <= 3'h0;
      di3_ff <= DI3_RST;
      adv_ff <= 32'h0000_0000;
    end else if (ce && wr_go && wr_ok) begin
      case (awaddr_ff)
        ADDR_FMIN: begin
          if (stopped && wr_hz <= fmax_ff) begin // [R21]
            fmin_ff <= wr_hz; // [R1]
          end
        end
        ADDR_FMAX: begin
          if (stopped) begin // [R21]
            if (!ext_ff && wr_hz == FMAX_EXT_CMD) begin
              ext_ff <= 1'b1; // [R3]
              fmax_ff <= wr_hz;
            end else if (ext_ff && wr_hz == FMAX_STD_CMD) begin
              ext_ff <= 1'b0; // [R5]
              fmax_ff <= wr_hz;
              panel_ff <= panel_ff - (panel_ff % PANEL_STEP_STD);
            end else if (wr_hz >= fmin_ff && wr_hz <= ceil_now) begin
              fmax_ff <= wr_hz; // [R2]
            end
          end
        end
        ADDR_ACC: acc_ff <= wr_ramp; // [R6]
        ADDR_DEC: dec_ff <= wr_ramp;
        ADDR_REFA: begin
          if (wdata_ff[31:0] <= 32'(REF_MAX)) begin
            refa_ff <= wdata_ff[2:0]; // [R9]
            if (wdata_ff[2:0] == 3'h3 || wdata_ff[2:0] == 3'h4) begin
              ssl_ff <= SSL_MOTPOT; // [R12]
              di3_ff <= DI3_MOTPOT;
            end
          end
        end
        ADDR_REFB: begin
          if (wdata_ff[31:0] <= 32'(REF_MAX)) begin
            refb_ff <= wdata_ff[2:0]; // [R13]
          end
        end
        ADDR_ILIM: ilim_ff <= wr_ilim; // [R15]
        ADDR_CURVE: begin
          if (wdata_ff[31:0] <= 32'(CURVE_MAX)) begin
            curve_ff <= wdata_ff[1:0];
          end
        end
        ADDR_OPT: opt_ff <= wdata_ff[0];
        ADDR_CONCEAL: conceal_ff <= wdata_ff[0];
        ADDR_LOCK: lock_ff <= wdata_ff[0];
        ADDR_PANEL: begin
          // Extended range keeps only 0.1 Hz steps
          panel_ff <= ext_ff ? wdata_ff[15:0] - (wdata_ff[15:0] % PANEL_STEP_EXT)
                             : wdata_ff[15:0]; // [R4]
        end
        ADDR_SSL: ssl_ff <= wdata_ff[2:0];
        ADDR_DI3: di3_ff <= wdata_ff[3:0];
        ADDR_ADV_GROUP: adv_ff <= wdata_ff;
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel
  logic [31:0] rd_val;
  always_comb begin
    case (s_axi_araddr)
      ADDR_FMIN: rd_val = 32'(fmin_ff);
      ADDR_FMAX: rd_val = 32'(fmax_ff);
      ADDR_ACC: rd_val = 32'(acc_ff);
      ADDR_DEC: rd_val = 32'(dec_ff);
      ADDR_REFA: rd_val = 32'(refa_ff);
      ADDR_REFB: rd_val = 32'(refb_ff);
      ADDR_ILIM: rd_val = 32'(ilim_ff);
      ADDR_CURVE: rd_val = 32'(curve_ff);
      ADDR_OPT: rd_val = 32'(opt_ff);
      ADDR_CONCEAL: rd_val = 32'(conceal_ff);
      ADDR_LOCK: rd_val = 32'(lock_ff);
      ADDR_PANEL: rd_val = 32'(panel_ff);
      ADDR_SSL: rd_val = 32'(ssl_ff);
      ADDR_DI3: rd_val = 32'(di3_ff);
      ADDR_STATUS: rd_val = {28'h0, source_select_input, ext_ff, !stopped,
                             run_ff == DRC_RUN_RAMP};
      ADDR_FOUT: rd_val = 32'(fout_ff);
      ADDR_ADV_GROUP: rd_val = conceal_ff ? 32'h0000_0000 : adv_ff; // [R19]
      default: rd_val = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (ce) begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= addr_bad(s_axi_araddr, conceal_ff) ? 2'b10 : 2'b00; // [R19]
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reference selection and motor potentiometer
  logic [2:0] ref_code;
  logic [15:0] ref_raw;
  logic [15:0] fmin_c;
  logic [15:0] fmax_c;
  logic [15:0] target;
  assign fmin_c = hz_to_centi(fmin_ff);
  assign fmax_c = hz_to_centi(fmax_ff);
  assign ref_code = source_select_input ? refb_ff : refa_ff; // [R14]
  always_comb begin
    case (ref_code) // [R9] [R13]
      3'h0: ref_raw = ain_volt_ref;
      3'h1: ref_raw = ain_curr_ref;
      3'h2: ref_raw = panel_ff;
      3'h3, 3'h4: ref_raw = motpot_ff;
      default: ref_raw = fmin_c;
    endcase
  end
  assign target = run_cmd ? clamp16(ref_raw, fmin_c, fmax_c) : fmin_c; // [R1]
  always_ff @(posedge clk) begin
    if (rst) begin
      motpot_ff <= 16'h0000;
    end else if (ce) begin
      if (stopped && ref_code == 3'h4) begin
        motpot_ff <= fmin_c; // [R11]
      end else if (tick && source_a_input_two && !source_a_input_three) begin
        motpot_ff <= clamp16(motpot_ff + MOTPOT_STEP, fmin_c, fmax_c); // [R10]
      end else if (tick && source_a_input_three && !source_a_input_two) begin
        motpot_ff <= (motpot_ff > fmin_c + MOTPOT_STEP) ? motpot_ff - MOTPOT_STEP
                                                       : fmin_c; // [R10]
      end else begin
        motpot_ff <= clamp16(motpot_ff, fmin_c, fmax_c);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ramp generator
  assign tick = (tick_cnt_ff == 18'(TICK_CYC - 1));
  always_ff @(posedge clk) begin
    if (rst) begin
      tick_cnt_ff <= 18'h0_0000;
    end else if (ce) begin
      tick_cnt_ff <= tick ? 18'h0_0000 : tick_cnt_ff + 18'h0_0001;
    end
  end
  // Step per tick in 1/65536 of 0.01 Hz: span / (time_in_ticks), time scaled
  logic [14:0] ramp_t;
  logic [22:0] eff_ticks;
  logic [31:0] span_fx;
  logic [31:0] step_fx;
  logic [31:0] acc_sum;
  assign ramp_t = (fout_ff < target) ? acc_ff : dec_ff;
  // Analog scale 255 = full time, lower shortens
  assign eff_ticks = 23'((32'(ramp_t) * 32'(TICKS_PER_DECI) * (32'(ain_ramp_scale) + 32'h1))
                     >> 8); // [R8]
  assign span_fx = 32'(fmax_c - fmin_c) << FRAC_W;
  assign step_fx = span_fx / ((eff_ticks == 23'h0) ? 32'h1 : 32'(eff_ticks)); // [R7]
  assign acc_sum = {fout_ff, frac_ff} + ((fout_ff < target) ? step_fx : -step_fx);
  always_ff @(posedge clk) begin
    if (rst) begin
      fout_ff <= 16'h0000;
      frac_ff <= '0;
      run_ff <= DRC_RUN_STOPPED;
    end else if (ce) begin
      case (run_ff)
        DRC_RUN_STOPPED: begin
          fout_ff <= fmin_c;
          frac_ff <= '0;
          if (run_cmd) begin
            run_ff <= DRC_RUN_RAMP;
          end
        end
        DRC_RUN_RAMP, DRC_RUN_HOLD: begin
          if (fout_ff == target) begin
            frac_ff <= '0;
            run_ff <= (!run_cmd && fout_ff == fmin_c) ? DRC_RUN_STOPPED : DRC_RUN_HOLD;
          end else if (tick) begin
            run_ff <= DRC_RUN_RAMP;
            frac_ff <= acc_sum[15:0];
            if (fout_ff < target) begin
              fout_ff <= (acc_sum[31:16] >= target || acc_sum[31:16] < fout_ff)
                         ? target : acc_sum[31:16]; // [R7]
            end else begin
              fout_ff <= (acc_sum[31:16] <= target || acc_sum[31:16] > fout_ff)
                         ? target : acc_sum[31:16]; // [R7]
            end
          end
        end
        default: run_ff <= DRC_RUN_STOPPED;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Voltage curve, current limit, outputs
  logic [15:0] fwp;
  logic [31:0] ratio;
  logic [9:0] v_curve;
  logic [10:0] v_sum;
  assign fwp = FWP_RST;
  assign ratio = (fout_ff >= fwp) ? 32'(V_FULL) : (32'(fout_ff) * 32'(V_FULL)) / 32'(fwp);
  assign v_curve = (curve_ff == 2'h1) ? 10'((ratio * ratio) / 32'(V_FULL)) // [R17]
                                      : ratio[9:0]; // [R16]
  assign v_sum = 11'(v_curve) + ((opt_ff && fout_ff < BOOST_FREQ) ? 11'(BOOST_V) : 11'h0); // [R18]
  always_ff @(posedge clk) begin
    if (rst) begin
      drive_out <= '0;
    end else if (ce) begin
      drive_out.fout <= fout_ff;
      drive_out.vout <= (v_sum > 11'(V_FULL)) ? V_FULL : v_sum[9:0];
      drive_out.ilim <= (ain_ilim < ilim_ff) ? ain_ilim : ilim_ff; // [R15]
      drive_out.running <= !stopped;
      drive_out.ext_range <= ext_ff;
    end
  end
endmodule : drc_top

// file: verif/drc_properties.sv
// Port checker for drc_top, attached by bind.
// Assumes ce held high and one AXI4-Lite transfer per direction at a time.
`timescale 1ns/1ps
module drc_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic run_cmd,
  input wire logic [4:0] ain_ilim,
  input wire drc_pkg::drc_out_s drive_out
);
  import drc_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("write address ready longer than one cycle");
  a_write_turn: assert property (s_axi_awready && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response not two cycles after take");
  a_bresp_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response stays after handshake");
  a_read_turn: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle after take");
  a_rdata_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data stays after handshake");
  a_fout_ceiling: assert property (drive_out.fout <= (drive_out.ext_range ? 16'hC350 : 16'h2EE0))
    else $error("output frequency above range ceiling");
  a_ext_stopped: assert property ($rose(drive_out.ext_range) |-> !$past(drive_out.running))
    else $error("extended range entered while running");
  a_run_start: assert property ($rose(drive_out.running) |-> $past(run_cmd) || $past(run_cmd, 2))
    else $error("drive started without run request");
  a_ilim_cap: assert property ($stable(ain_ilim) [*3] |-> drive_out.ilim <= ain_ilim)
    else $error("current limit above analog limit");
endmodule : drc_properties

bind drc_top drc_properties u_props (.clk(clk), .rst(rst), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .run_cmd(run_cmd), .ain_ilim(ain_ilim), .drive_out(drive_out));

// file: verif/drc_partner.sv
// Operator switches and analog sources facing drc_top.
// Assumes the bench asks for run and source selection by level.
`timescale 1ns/1ps
module drc_partner #(
  parameter logic [15:0] VOLT_REF = 16'h0BB8,
  parameter logic [15:0] CURR_REF = 16'h0FA0,
  parameter logic [7:0] RAMP_SCALE = 8'hFF,
  parameter logic [4:0] ILIM_AIN = 5'h0A
) (
  input wire logic clk,
  input wire logic run_req,
  input wire logic sel_req,
  output logic run_cmd = 1'b0,
  output logic source_a_input_two = 1'b0,
  output logic source_a_input_three = 1'b0,
  output logic source_select_input = 1'b0,
  output logic [15:0] ain_volt_ref,
  output logic [15:0] ain_curr_ref,
  output logic [7:0] ain_ramp_scale,
  output logic [4:0] ain_ilim
);
  // Switch contacts change only after a clock edge
  always @(posedge clk) begin
    run_cmd <= run_req;
    source_select_input <= sel_req;
    source_a_input_two <= 1'b0;
    source_a_input_three <= 1'b0;
  end
  assign ain_volt_ref = VOLT_REF;
  assign ain_curr_ref = CURR_REF;
  assign ain_ramp_scale = RAMP_SCALE;
  assign ain_ilim = ILIM_AIN;
endmodule : drc_partner

// file: verif/test_drc_top.sv
// Self-checking bench for drc_top over AXI4-Lite.
// Assumes drc_partner supplies operator inputs; ce and wstrb held constant.
`timescale 1ns/1ps
module test_drc_top;
  import drc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic run_cmd, source_a_input_two, source_a_input_three, source_select_input;
  logic [15:0] ain_volt_ref, ain_curr_ref;
  logic [7:0] ain_ramp_scale;
  logic [4:0] ain_ilim;
  drc_out_s drive_out;
  logic run_req = 1'b0;
  logic sel_req = 1'b0;
  int bad_count = 0;
  int num_checks = 0;
  logic [7:0] dflt_a [13] = '{ADDR_FMIN, ADDR_FMAX, ADDR_ACC, ADDR_DEC, ADDR_REFA, ADDR_REFB,
    ADDR_ILIM, ADDR_CURVE, ADDR_OPT, ADDR_CONCEAL, ADDR_LOCK, ADDR_SSL, ADDR_DI3};
  logic [31:0] dflt_v [13] = '{32'h0, 32'h3C, 32'h1E, 32'h1E, 32'h1, 32'h0, 32'hF, 32'h0,
    32'h0, 32'h0, 32'h0, 32'h0, 32'h7};

  always #2.5 clk = ~clk;
  drc_top uut (.*);
  drc_partner u_partner (.clk(clk), .run_req(run_req), .sel_req(sel_req), .run_cmd(run_cmd),
    .source_a_input_two(source_a_input_two), .source_a_input_three(source_a_input_three),
    .source_select_input(source_select_input), .ain_volt_ref(ain_volt_ref),
    .ain_curr_ref(ain_curr_ref), .ain_ramp_scale(ain_ramp_scale), .ain_ilim(ain_ilim));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic [1:0] resp;
    n = 0;
    resp = 2'b11;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (resp === 2'b11 && n < 200) begin
      @(posedge clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
    check($sformatf("bresp %h", a), {30'h0, er}, {30'h0, resp});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    logic [1:0] resp;
    logic [31:0] data;
    n = 0;
    resp = 2'b11;
    data = 32'h0000_0000;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (resp === 2'b11 && n < 200) begin
      @(posedge clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        resp = s_axi_rresp;
        data = s_axi_rdata;
        s_axi_rready <= 1'b0;
      end
    end
    check($sformatf("rresp %h", a), {30'h0, er}, {30'h0, resp});
    if (er == 2'b00) check($sformatf("rdata %h", a), exp, data);
  endtask : rd

  task automatic fout_is(input logic [15:0] f);
    for (int i = 0; i < 50 && drive_out.fout !== f; i++) @(posedge clk);
    check("fout", {16'h0, f}, {16'h0, drive_out.fout});
  endtask : fout_is

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    bad_count++;
    report_and_stop();
  end

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 13; i++) rd(dflt_a[i], dflt_v[i], 2'b00);
    check("ilim", 32'h0A, {27'h0, drive_out.ilim});
    rd(8'h44, 32'h0, 2'b10);
    wr(8'h44, 32'h0, 2'b10);
    wr(8'h02, 32'h0, 2'b10);
    wr(ADDR_FMIN, 32'h5, 2'b00);
    fout_is(16'h01F4);
    wr(ADDR_FMAX, 32'h78, 2'b00);
    rd(ADDR_STATUS, 32'h4, 2'b00);
    check("ext", 32'h1, {31'h0, drive_out.ext_range});
    wr(ADDR_PANEL, 32'h04D2, 2'b00);
    rd(ADDR_PANEL, 32'h04CE, 2'b00);
    wr(ADDR_FMAX, 32'h1F4, 2'b00);
    rd(ADDR_FMAX, 32'h1F4, 2'b00);
    wr(ADDR_FMAX, 32'h77, 2'b00);
    rd(ADDR_STATUS, 32'h0, 2'b00);
    wr(ADDR_FMAX, 32'hC8, 2'b00);
    rd(ADDR_FMAX, 32'h77, 2'b00);
    wr(ADDR_PANEL, 32'h04D2, 2'b00);
    rd(ADDR_PANEL, 32'h04D2, 2'b00);
    for (int c = 0; c < 5; c++) begin
      wr(ADDR_REFB, 32'(c), 2'b00);
      rd(ADDR_REFB, 32'(c), 2'b00);
      wr(ADDR_REFA, 32'(c), 2'b00);
      rd(ADDR_REFA, 32'(c), 2'b00);
      if (c < 3) wr(ADDR_CURVE, 32'(c), 2'b00);
      if (c < 3) rd(ADDR_CURVE, 32'(c), 2'b00);
    end
    rd(ADDR_SSL, 32'h4, 2'b00);
    rd(ADDR_DI3, 32'hA, 2'b00);
    wr(ADDR_OPT, 32'h1, 2'b00);
    rd(ADDR_OPT, 32'h1, 2'b00);
    wr(ADDR_LOCK, 32'h1, 2'b00);
    wr(ADDR_FMIN, 32'h7, 2'b10);
    rd(ADDR_FMIN, 32'h5, 2'b00);
    wr(ADDR_LOCK, 32'h0, 2'b00);
    wr(ADDR_CONCEAL, 32'h1, 2'b00);
    rd(ADDR_ADV_GROUP, 32'h0, 2'b10);
    rd(ADDR_FMIN, 32'h5, 2'b00);
    wr(ADDR_CONCEAL, 32'h0, 2'b00);
    wr(ADDR_ADV_GROUP, 32'h5A, 2'b00);
    rd(ADDR_ADV_GROUP, 32'h5A, 2'b00);
    sel_req <= 1'b1;
    rd(ADDR_STATUS, 32'h8, 2'b00);
    sel_req <= 1'b0;
    run_req <= 1'b1;
    for (int i = 0; i < 20 && drive_out.running !== 1'b1; i++) @(posedge clk);
    check("running", 32'h1, {31'h0, drive_out.running});
    wr(ADDR_FMIN, 32'h9, 2'b00);
    rd(ADDR_FMIN, 32'h5, 2'b00);
    run_req <= 1'b0;
    for (int i = 0; i < 100 && drive_out.running !== 1'b0; i++) @(posedge clk);
    check("running", 32'h0, {31'h0, drive_out.running});
    wr(ADDR_FMIN, 32'h9, 2'b00);
    fout_is(16'h0384);
    wr(ADDR_CURVE, 32'h0, 2'b00);
    rd(ADDR_CURVE, 32'h0, 2'b00);
    check("vout", 32'hCC, {22'h0, drive_out.vout});
    wr(ADDR_CURVE, 32'h1, 2'b00);
    rd(ADDR_CURVE, 32'h1, 2'b00);
    check("vout", 32'h49, {22'h0, drive_out.vout});
    report_and_stop();
  end
endmodule : test_drc_top
